/* File: shared/mbio_pkg.sv */
package mbio_pkg;

  // ----------------------------------------------------------------
  // function codes and exception codes
  // ----------------------------------------------------------------
  localparam logic [7:0] FC_RD_ANA_IN = 8'h04;
  localparam logic [7:0] FC_WR_DIG_OUT = 8'h05;
  localparam logic [7:0] FC_WR_ANA_OUT = 8'h06;
  localparam logic [7:0] FC_WR_DIG_OUTS = 8'h0F;
  localparam logic [7:0] FC_WR_ANA_OUTS = 8'h10;
  localparam logic [7:0] FC_EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_VALUE = 8'h03;

  // ----------------------------------------------------------------
  // field values
  // ----------------------------------------------------------------
  localparam logic [15:0] DIG_ON_VAL = 16'hFF00;
  localparam logic [15:0] DIG_OFF_VAL = 16'h0000;
  localparam logic [15:0] PROTO_ID = 16'h0000;
  localparam logic [15:0] LEN_ECHO = 16'h0006;
  localparam logic [15:0] LEN_EXC = 16'h0003;
  localparam logic [15:0] LEN_RD_BASE = 16'h0003;
  localparam logic [15:0] LEN_PREFIX = 16'h0006;

  // ----------------------------------------------------------------
  // byte offsets within a frame
  // ----------------------------------------------------------------
  localparam logic [8:0] OFS_TID_HI = 9'h000;
  localparam logic [8:0] OFS_TID_LO = 9'h001;
  localparam logic [8:0] OFS_PID_HI = 9'h002;
  localparam logic [8:0] OFS_PID_LO = 9'h003;
  localparam logic [8:0] OFS_LEN_HI = 9'h004;
  localparam logic [8:0] OFS_LEN_LO = 9'h005;
  localparam logic [8:0] OFS_UID = 9'h006;
  localparam logic [8:0] OFS_FC = 9'h007;
  localparam logic [8:0] OFS_ADDR_HI = 9'h008;
  localparam logic [8:0] OFS_ADDR_LO = 9'h009;
  localparam logic [8:0] OFS_QTY_HI = 9'h00A;
  localparam logic [8:0] OFS_QTY_LO = 9'h00B;
  localparam logic [8:0] OFS_BCNT = 9'h00C;
  localparam logic [8:0] OFS_DATA = 9'h00D;
  localparam logic [8:0] OFS_RD_DATA = 9'h009;
  localparam logic [8:0] FRAME_FIXED = 9'h00C;
  localparam logic [8:0] FRAME_EXC = 9'h009;
  localparam logic [8:0] FRAME_MIN = 9'h008;
  localparam logic [8:0] CNT_MAX = 9'h1FF;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_RECV = 4'h1,
    ST_CHECK = 4'h2,
    ST_EXEC = 4'h4,
    ST_SEND = 4'h8
  } mbio_state_e;

endpackage

/* File: rtl/mbio_rxbuf.sv */
`timescale 1ns/1ns
`default_nettype none

module mbio_rxbuf #(
  parameter int AW = 8
) (
  // clock
  input wire logic i_clk,
  // write side
  input wire logic i_wr_en,
  input wire logic [AW-1:0] i_wr_addr,
  input wire logic [7:0] i_wr_data,
  // read side, two consecutive bytes
  input wire logic [AW-1:0] i_rd_addr,
  output logic [7:0] o_rd_byte0,
  output logic [7:0] o_rd_byte1
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  // no reset: only bytes of the current frame are ever read back
  logic [7:0] mem_q [2**AW];
  wire logic [AW-1:0] rd_next;

  assign rd_next = i_rd_addr + AW'(1);
  assign o_rd_byte0 = mem_q[i_rd_addr];
  assign o_rd_byte1 = mem_q[rd_next];

  always_ff @(posedge i_clk) begin
    if (i_wr_en) begin
      mem_q[i_wr_addr] <= i_wr_data;
    end
  end

endmodule

`default_nettype wire

/* File: rtl/mbio_request_handler.sv */
`timescale 1ns/1ns
`default_nettype none

module mbio_request_handler
  import mbio_pkg::*;
#(
  parameter int NUM_DIG_OUT = 16,
  parameter int NUM_ANA_IN = 8,
  parameter int NUM_ANA_OUT = 8,
  parameter int BUF_AW = 8
) (
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_SRST,
  // own unit identifier
  input wire logic [7:0] I_UNIT_ID,
  // request byte stream
  input wire logic I_RX_VALID,
  input wire logic [7:0] I_RX_DATA,
  input wire logic I_RX_LAST,
  input wire logic I_RX_ERR,
  output logic O_RX_READY,
  // response byte stream
  output logic O_TX_VALID,
  output logic [7:0] O_TX_DATA,
  output logic O_TX_LAST,
  input wire logic I_TX_READY,
  // digital output latches
  output logic [NUM_DIG_OUT-1:0] O_DIG_OUT,
  // analog output channel write port
  output logic O_ANA_OUT_WE,
  output logic [15:0] O_ANA_OUT_ADDR,
  output logic [15:0] O_ANA_OUT_DATA,
  // analog input channel read port
  output logic [15:0] O_ANA_IN_SEL,
  input wire logic [15:0] I_ANA_IN_DATA
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic past_end(input logic [15:0] a,
                                    input logic [15:0] q,
                                    input int n);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, q};
    past_end = s > 17'(n);
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  mbio_state_e state_q, state_d;
  logic [8:0] rx_cnt_q;
  logic err_q;
  logic [15:0] tid_q, pid_q, len_q, addr_q, qty_q;
  logic [7:0] uid_q, fc_q, bcnt_q, exc_q, exc_d;
  logic [15:0] ex_i_q;
  logic [8:0] tx_idx_q;
  logic tx_valid_q, tx_last_q;
  logic [7:0] tx_data_q;
  logic [NUM_DIG_OUT-1:0] dig_q;
  logic ana_we_q;
  logic [15:0] ana_addr_q, ana_data_q;

  // ----------------------------------------------------------------
  // receive path
  // ----------------------------------------------------------------
  wire logic rx_fire;
  wire logic rx_clr;
  wire logic [8:0] rx_rel;
  wire logic buf_we;
  wire logic [BUF_AW-1:0] buf_rd_addr;
  wire logic [7:0] buf_b0, buf_b1;

  assign O_RX_READY = (state_q == ST_RECV);
  assign rx_fire = I_RX_VALID && O_RX_READY;
  assign rx_clr = (state_d == ST_RECV) && (state_q != ST_RECV);
  assign rx_rel = rx_cnt_q - OFS_DATA;
  assign buf_we = rx_fire && (rx_cnt_q >= OFS_DATA)
                  && ((rx_rel >> BUF_AW) == 9'h000);

  always_ff @(posedge I_CLK) begin
    if (I_SRST || rx_clr) begin
      rx_cnt_q <= 9'h000;
      err_q <= 1'b0;
    end else if (rx_fire) begin
      if (rx_cnt_q != CNT_MAX) begin
        rx_cnt_q <= rx_cnt_q + 9'h001;
      end
      // overlong frames are treated as damaged
      if (I_RX_ERR || rx_cnt_q == CNT_MAX) begin
        err_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      tid_q <= 16'h0000;
      pid_q <= 16'h0000;
      len_q <= 16'h0000;
      uid_q <= 8'h00;
      fc_q <= 8'h00;
      addr_q <= 16'h0000;
      qty_q <= 16'h0000;
      bcnt_q <= 8'h00;
    end else if (rx_fire) begin
      // high byte arrives first in every field
      case (rx_cnt_q)
        OFS_TID_HI: tid_q[15:8] <= I_RX_DATA;
        OFS_TID_LO: tid_q[7:0] <= I_RX_DATA;
        OFS_PID_HI: pid_q[15:8] <= I_RX_DATA;
        OFS_PID_LO: pid_q[7:0] <= I_RX_DATA;
        OFS_LEN_HI: len_q[15:8] <= I_RX_DATA;
        OFS_LEN_LO: len_q[7:0] <= I_RX_DATA;
        OFS_UID: uid_q <= I_RX_DATA;
        OFS_FC: fc_q <= I_RX_DATA;
        OFS_ADDR_HI: addr_q[15:8] <= I_RX_DATA;
        OFS_ADDR_LO: addr_q[7:0] <= I_RX_DATA;
        OFS_QTY_HI: qty_q[15:8] <= I_RX_DATA;
        OFS_QTY_LO: qty_q[7:0] <= I_RX_DATA;
        OFS_BCNT: bcnt_q <= I_RX_DATA;
        default: ;
      endcase
    end
  end

  mbio_rxbuf #(
    .AW(BUF_AW)
  ) u_rxbuf (
    .i_clk(I_CLK),
    .i_wr_en(buf_we),
    .i_wr_addr(rx_rel[BUF_AW-1:0]),
    .i_wr_data(I_RX_DATA),
    .i_rd_addr(buf_rd_addr),
    .o_rd_byte0(buf_b0),
    .o_rd_byte1(buf_b1)
  );

  // ----------------------------------------------------------------
  // frame checks
  // ----------------------------------------------------------------
  wire logic frame_ok;
  wire logic fixed_sz;
  wire logic data_sz;
  wire logic [16:0] bits_bytes;

  assign frame_ok = !err_q && (rx_cnt_q >= FRAME_MIN)
                    && (pid_q == PROTO_ID)
                    && (len_q + LEN_PREFIX == {7'h00, rx_cnt_q})
                    && (uid_q == I_UNIT_ID);
  assign fixed_sz = (rx_cnt_q == FRAME_FIXED);
  assign data_sz = (rx_cnt_q == OFS_DATA + {1'b0, bcnt_q});
  assign bits_bytes = ({1'b0, qty_q} + 17'h0_0007) >> 3;

  always_comb begin
    exc_d = EXC_NONE;
    case (fc_q)
      FC_RD_ANA_IN: begin
        if (!fixed_sz || qty_q == 16'h0000) begin
          exc_d = EXC_VALUE;
        end else if (past_end(addr_q, qty_q, NUM_ANA_IN)) begin
          exc_d = EXC_ADDR;
        end
      end
      FC_WR_DIG_OUT: begin
        if (!fixed_sz
            || (qty_q != DIG_ON_VAL && qty_q != DIG_OFF_VAL)) begin
          exc_d = EXC_VALUE;
        end else if (past_end(addr_q, 16'h0001, NUM_DIG_OUT)) begin
          exc_d = EXC_ADDR;
        end
      end
      FC_WR_ANA_OUT: begin
        if (!fixed_sz) begin
          exc_d = EXC_VALUE;
        end else if (past_end(addr_q, 16'h0001, NUM_ANA_OUT)) begin
          exc_d = EXC_ADDR;
        end
      end
      FC_WR_DIG_OUTS: begin
        if (!data_sz || qty_q == 16'h0000
            || bits_bytes != {9'h000, bcnt_q}) begin
          exc_d = EXC_VALUE;
        end else if (past_end(addr_q, qty_q, NUM_DIG_OUT)) begin
          exc_d = EXC_ADDR;
        end
      end
      FC_WR_ANA_OUTS: begin
        if (!data_sz || qty_q == 16'h0000
            || {qty_q, 1'b0} != {9'h000, bcnt_q}) begin
          exc_d = EXC_VALUE;
        end else if (past_end(addr_q, qty_q, NUM_ANA_OUT)) begin
          exc_d = EXC_ADDR;
        end
      end
      default: exc_d = EXC_FUNC;
    endcase
  end

  // ----------------------------------------------------------------
  // execution
  // ----------------------------------------------------------------
  wire logic is_multi;
  wire logic ex_done;
  wire logic [15:0] tgt;
  wire logic dig_wr;
  wire logic dig_val;
  wire logic ana_wr;
  wire logic [15:0] bit_byte;
  wire logic [15:0] word_byte;

  assign is_multi = (fc_q == FC_WR_DIG_OUTS) || (fc_q == FC_WR_ANA_OUTS);
  assign ex_done = !is_multi || (ex_i_q == qty_q - 16'h0001);
  assign tgt = addr_q + ex_i_q;
  assign bit_byte = ex_i_q >> 3;
  assign word_byte = ex_i_q << 1;
  assign buf_rd_addr = (fc_q == FC_WR_DIG_OUTS) ? bit_byte[BUF_AW-1:0]
                                                 : word_byte[BUF_AW-1:0];
  assign dig_wr = (state_q == ST_EXEC)
                  && (fc_q == FC_WR_DIG_OUT || fc_q == FC_WR_DIG_OUTS);
  // lsb of the first byte is the start output; bits past qty never read
  assign dig_val = (fc_q == FC_WR_DIG_OUT) ? (qty_q == DIG_ON_VAL)
                                           : buf_b0[ex_i_q[2:0]];
  assign ana_wr = (state_q == ST_EXEC)
                  && (fc_q == FC_WR_ANA_OUT || fc_q == FC_WR_ANA_OUTS);

  always_ff @(posedge I_CLK) begin
    if (I_SRST || state_q != ST_EXEC) begin
      ex_i_q <= 16'h0000;
    end else begin
      ex_i_q <= ex_i_q + 16'h0001;
    end
  end

  genvar k;
  generate
    for (k = 0; k < NUM_DIG_OUT; k++) begin : g_dig
      always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
          dig_q[k] <= 1'b0;
        end else if (dig_wr && tgt == 16'(k)) begin
          dig_q[k] <= dig_val;
        end
      end
    end
  endgenerate

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      ana_we_q <= 1'b0;
      ana_addr_q <= 16'h0000;
      ana_data_q <= 16'h0000;
    end else begin
      ana_we_q <= ana_wr;
      if (ana_wr) begin
        ana_addr_q <= tgt;
        ana_data_q <= (fc_q == FC_WR_ANA_OUT) ? qty_q
                                              : {buf_b0, buf_b1};
      end
    end
  end

  assign O_DIG_OUT = dig_q;
  assign O_ANA_OUT_WE = ana_we_q;
  assign O_ANA_OUT_ADDR = ana_addr_q;
  assign O_ANA_OUT_DATA = ana_data_q;

  // ----------------------------------------------------------------
  // response path
  // ----------------------------------------------------------------
  wire logic is_exc;
  wire logic is_rd;
  wire logic [8:0] tx_total;
  wire logic [15:0] resp_len;
  wire logic [8:0] rd_off;
  wire logic tx_load;
  wire logic tx_end;
  logic [7:0] tx_byte;

  assign is_exc = (exc_q != EXC_NONE);
  assign is_rd = (fc_q == FC_RD_ANA_IN) && !is_exc;
  // narrow count limits one read to 251 channels
  assign tx_total = is_exc ? FRAME_EXC
                  : is_rd ? OFS_RD_DATA + {qty_q[7:0], 1'b0}
                  : FRAME_FIXED;
  assign resp_len = is_exc ? LEN_EXC
                  : is_rd ? LEN_RD_BASE + {qty_q[14:0], 1'b0}
                  : LEN_ECHO;
  assign rd_off = tx_idx_q - OFS_RD_DATA;
  assign O_ANA_IN_SEL = addr_q + {8'h00, rd_off[8:1]};
  assign tx_load = (state_q == ST_SEND) && (!tx_valid_q || I_TX_READY)
                   && (tx_idx_q < tx_total);
  assign tx_end = tx_valid_q && I_TX_READY && tx_last_q;

  always_comb begin
    tx_byte = 8'h00;
    if (is_rd && tx_idx_q >= OFS_RD_DATA) begin
      tx_byte = rd_off[0] ? I_ANA_IN_DATA[7:0]
                          : I_ANA_IN_DATA[15:8];
    end else begin
      case (tx_idx_q)
        OFS_TID_HI: tx_byte = tid_q[15:8];
        OFS_TID_LO: tx_byte = tid_q[7:0];
        OFS_PID_HI: tx_byte = pid_q[15:8];
        OFS_PID_LO: tx_byte = pid_q[7:0];
        OFS_LEN_HI: tx_byte = resp_len[15:8];
        OFS_LEN_LO: tx_byte = resp_len[7:0];
        OFS_UID: tx_byte = uid_q;
        OFS_FC: tx_byte = is_exc ? (fc_q | FC_EXC_FLAG) : fc_q;
        OFS_ADDR_HI: tx_byte = is_exc ? exc_q
                             : is_rd ? {qty_q[6:0], 1'b0}
                             : addr_q[15:8];
        OFS_ADDR_LO: tx_byte = addr_q[7:0];
        OFS_QTY_HI: tx_byte = qty_q[15:8];
        OFS_QTY_LO: tx_byte = qty_q[7:0];
        default: tx_byte = 8'h00;
      endcase
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      tx_valid_q <= 1'b0;
      tx_last_q <= 1'b0;
      tx_data_q <= 8'h00;
    end else if (tx_load) begin
      tx_valid_q <= 1'b1;
      tx_data_q <= tx_byte;
      tx_last_q <= (tx_idx_q == tx_total - 9'h001);
    end else if (I_TX_READY) begin
      tx_valid_q <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST || state_q != ST_SEND) begin
      tx_idx_q <= 9'h000;
    end else if (tx_load) begin
      tx_idx_q <= tx_idx_q + 9'h001;
    end
  end

  assign O_TX_VALID = tx_valid_q;
  assign O_TX_DATA = tx_data_q;
  assign O_TX_LAST = tx_last_q;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RECV: begin
        if (rx_fire && I_RX_LAST) begin
          state_d = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (!frame_ok) begin
          state_d = ST_RECV;
        end else if (exc_d != EXC_NONE) begin
          state_d = ST_SEND;
        end else begin
          state_d = ST_EXEC;
        end
      end
      ST_EXEC: begin
        // answer starts only after the last store is issued
        if (ex_done) begin
          state_d = ST_SEND;
        end
      end
      ST_SEND: begin
        if (tx_end) begin
          state_d = ST_RECV;
        end
      end
      default: state_d = ST_RECV;
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      state_q <= ST_RECV;
      exc_q <= EXC_NONE;
    end else begin
      state_q <= state_d;
      if (state_q == ST_CHECK) begin
        exc_q <= exc_d;
      end
    end
  end

endmodule

`default_nettype wire

/* File: tb/mbio_request_handler_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module mbio_request_handler_sva #(
  parameter int NUM_DIG_OUT = 16,
  parameter int NUM_ANA_OUT = 8
) (
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_SRST,
  // request stream
  input wire logic I_RX_VALID,
  input wire logic I_RX_LAST,
  input wire logic I_RX_ERR,
  input wire logic O_RX_READY,
  // response stream
  input wire logic O_TX_VALID,
  input wire logic [7:0] O_TX_DATA,
  input wire logic O_TX_LAST,
  input wire logic I_TX_READY,
  // output latches
  input wire logic [NUM_DIG_OUT-1:0] O_DIG_OUT,
  input wire logic O_ANA_OUT_WE,
  input wire logic [15:0] O_ANA_OUT_ADDR
);
  // ------
  // damaged-frame tracking
  // ------
  logic bad_q;
  wire take = I_RX_VALID & O_RX_READY;
  wire take_end = take & I_RX_LAST;
  wire bad_end = take_end & (bad_q | I_RX_ERR);
  always_ff @(posedge I_CLK) begin
    if (I_SRST) bad_q <= 1'b0;
    else if (take) bad_q <= ~I_RX_LAST & (bad_q | I_RX_ERR);
  end
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SRST);
  // ------
  // properties
  // ------
  sequence s_quiet; !O_RX_READY && !O_TX_VALID; endsequence
  sequence s_back; O_RX_READY && !O_TX_VALID; endsequence
  property p_drop; bad_end |=> s_quiet ##1 s_back; endproperty
  a_drop: assert property (p_drop)
    else $error("damaged frame answered");
  property p_stop; take_end |=> !O_RX_READY; endproperty
  a_stop: assert property (p_stop)
    else $error("receive open after frame end");
  property p_bound; take_end |-> ##[2:1000] O_RX_READY; endproperty
  a_bound: assert property (p_bound)
    else $error("request never finished");
  property p_end; O_TX_VALID && O_TX_LAST && I_TX_READY |=> s_back;
  endproperty
  a_end: assert property (p_end)
    else $error("receive not resumed after last byte");
  property p_hold;
    O_TX_VALID && !I_TX_READY |=>
      O_TX_VALID && $stable(O_TX_DATA) && $stable(O_TX_LAST);
  endproperty
  a_hold: assert property (p_hold)
    else $error("response byte changed while stalled");
  property p_we_tx; O_ANA_OUT_WE |-> s_quiet; endproperty
  a_we_tx: assert property (p_we_tx)
    else $error("analog write after answer began");
  property p_we_rng; O_ANA_OUT_WE |-> O_ANA_OUT_ADDR < NUM_ANA_OUT;
  endproperty
  a_we_rng: assert property (p_we_rng)
    else $error("analog write out of range");
  property p_we_seq;
    $past(O_ANA_OUT_WE) && O_ANA_OUT_WE |->
      O_ANA_OUT_ADDR == $past(O_ANA_OUT_ADDR) + 16'h0001;
  endproperty
  a_we_seq: assert property (p_we_seq)
    else $error("analog writes not consecutive");
  property p_dig; !$stable(O_DIG_OUT) |-> s_quiet; endproperty
  a_dig: assert property (p_dig)
    else $error("digital outputs changed outside execution");
endmodule
bind mbio_request_handler mbio_request_handler_sva #(
  .NUM_DIG_OUT(NUM_DIG_OUT),
  .NUM_ANA_OUT(NUM_ANA_OUT)
) u_mbio_request_handler_sva (
  .I_CLK(I_CLK), .I_SRST(I_SRST), .I_RX_VALID(I_RX_VALID),
  .I_RX_LAST(I_RX_LAST), .I_RX_ERR(I_RX_ERR), .O_RX_READY(O_RX_READY),
  .O_TX_VALID(O_TX_VALID), .O_TX_DATA(O_TX_DATA), .O_TX_LAST(O_TX_LAST),
  .I_TX_READY(I_TX_READY), .O_DIG_OUT(O_DIG_OUT),
  .O_ANA_OUT_WE(O_ANA_OUT_WE), .O_ANA_OUT_ADDR(O_ANA_OUT_ADDR)
);
`default_nettype wire

/* File: tb/mbio_client.sv */
`timescale 1ns/1ns
`default_nettype none
module mbio_client (
  // clock
  input wire logic i_clk,
  // stall control
  input wire logic i_stall,
  // analog input channel read port
  input wire logic [15:0] i_sel,
  output logic [15:0] o_ana_data,
  // response sink
  output logic o_tx_ready
);
  logic [1:0] cnt_q = 2'h0;
  // value carries its index so a wrong channel shows up
  assign o_ana_data = {8'hA5, i_sel[7:0]};
  // stalls three cycles in four to exercise the hold path
  assign o_tx_ready = ~i_stall | (cnt_q == 2'h3);
  // plain always: the counter starts from its declared value, no reset pin
  always @(posedge i_clk) begin
    cnt_q <= cnt_q + 2'h1;
  end
endmodule
`default_nettype wire

/* File: tb/mbio_request_handler_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module mbio_request_handler_bench;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic rx_valid = 1'b0;
  logic [7:0] rx_data = 8'h00;
  logic rx_last = 1'b0;
  logic rx_err = 1'b0;
  logic stall = 1'b0;
  logic [7:0] uid = 8'h01;
  wire rx_ready, tx_valid, tx_last, tx_ready, we;
  wire [7:0] tx_data;
  wire [15:0] dig, waddr, wdata, sel, ana;
  int err_count = 0;
  int n_tests = 0;
  int n_last;
  logic [15:0] tid = 16'h0100;
  logic [7:0] pdu[$], body[$], rsp[$];
  logic [15:0] wa[$], wd[$];
  int wpos[$];
  always #25 clk = ~clk;
  mbio_request_handler u_mbio_request_handler (
    .I_CLK(clk), .I_SRST(srst), .I_UNIT_ID(uid),
    .I_RX_VALID(rx_valid), .I_RX_DATA(rx_data), .I_RX_LAST(rx_last),
    .I_RX_ERR(rx_err), .O_RX_READY(rx_ready), .O_TX_VALID(tx_valid),
    .O_TX_DATA(tx_data), .O_TX_LAST(tx_last), .I_TX_READY(tx_ready),
    .O_DIG_OUT(dig), .O_ANA_OUT_WE(we), .O_ANA_OUT_ADDR(waddr),
    .O_ANA_OUT_DATA(wdata), .O_ANA_IN_SEL(sel), .I_ANA_IN_DATA(ana));
  mbio_client u_mbio_client (.i_clk(clk), .i_stall(stall), .i_sel(sel),
    .o_ana_data(ana), .o_tx_ready(tx_ready));
  // ------
  // monitor
  // ------
  always @(posedge clk) begin
    if (tx_valid && tx_ready) begin
      rsp.push_back(tx_data);
      if (tx_last) n_last++;
    end
    if (we) begin
      wa.push_back(waddr);
      wd.push_back(wdata);
      wpos.push_back(rsp.size());
    end
  end
  // ------
  // shared tasks
  // ------
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask
  task automatic xact(input logic [7:0] u, input logic er,
                      input logic [15:0] ladj);
    logic [7:0] f[$];
    logic [15:0] ln;
    int k;
    tid = tid + 16'h0001;
    rsp.delete();
    wa.delete();
    wd.delete();
    wpos.delete();
    n_last = 0;
    ln = 16'(pdu.size() + 1) + ladj;
    f = {tid[15:8], tid[7:0], 8'h00, 8'h00, ln[15:8], ln[7:0], u, pdu};
    foreach (f[i]) begin
      rx_valid <= 1'b1;
      rx_data <= f[i];
      rx_last <= (i == f.size() - 1);
      rx_err <= er && (i == 3);
      @(posedge clk);
    end
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    rx_err <= 1'b0;
    k = 0;
    @(negedge clk);
    while (!rx_ready && k < 2000) begin
      @(negedge clk);
      k++;
    end
    chk("receive resumed", 16'h0001, {15'h0000, rx_ready});
    @(posedge clk);
  endtask
  task automatic rsp_ok(input logic [15:0] ln);
    logic [7:0] e[$];
    e = {tid[15:8], tid[7:0], 8'h00, 8'h00, ln[15:8], ln[7:0], 8'h01, body};
    chk("rsp size", 16'(e.size()), 16'(rsp.size()));
    chk("last marks", 16'h0001, 16'(n_last));
    foreach (e[i]) if (i < rsp.size()) chk("rsp byte", {8'h00, e[i]},
                                          {8'h00, rsp[i]});
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ------
  // scenarios
  // ------
  task automatic s_read;
    stall <= 1'b1;
    pdu = {8'h04, 8'h00, 8'h01, 8'h00, 8'h02};
    xact(8'h01, 1'b0, 16'h0000);
    body = {8'h04, 8'h04, 8'hA5, 8'h01, 8'hA5, 8'h02};
    rsp_ok(16'h0007);
    stall <= 1'b0;
  endtask
  task automatic s_coil;
    pdu = {8'h05, 8'h00, 8'h03, 8'hFF, 8'h00};
    xact(8'h01, 1'b0, 16'h0000);
    body = pdu;
    rsp_ok(16'h0006);
    chk("dig on", 16'h0008, dig);
    pdu = {8'h05, 8'h00, 8'h03, 8'h00, 8'h00};
    xact(8'h01, 1'b0, 16'h0000);
    chk("dig off", 16'h0000, dig);
    pdu = {8'h05, 8'h00, 8'h03, 8'h12, 8'h34};
    xact(8'h01, 1'b0, 16'h0000);
    body = {8'h85, 8'h03};
    rsp_ok(16'h0003);
  endtask
  task automatic s_reg;
    pdu = {8'h06, 8'h00, 8'h05, 8'h55, 8'hFF};
    xact(8'h01, 1'b0, 16'h0000);
    body = pdu;
    rsp_ok(16'h0006);
    chk("we count", 16'h0001, 16'(wa.size()));
    chk("we addr", 16'h0005, wa[0]);
    chk("we data", 16'h55FF, wd[0]);
    chk("we before tx", 16'h0000, 16'(wpos[0]));
  endtask
  task automatic s_coils;
    pdu = {8'h0F, 8'h00, 8'h00, 8'h00, 8'h0A, 8'h02, 8'h02, 8'hFD};
    xact(8'h01, 1'b0, 16'h0000);
    body = {8'h0F, 8'h00, 8'h00, 8'h00, 8'h0A};
    rsp_ok(16'h0006);
    chk("dig packed", 16'h0102, dig);
  endtask
  task automatic s_regs;
    pdu = {8'h10, 8'h00, 8'h06, 8'h00, 8'h02, 8'h04,
           8'h00, 8'h0A, 8'h00, 8'h64};
    xact(8'h01, 1'b0, 16'h0000);
    body = {8'h10, 8'h00, 8'h06, 8'h00, 8'h02};
    rsp_ok(16'h0006);
    chk("we count", 16'h0002, 16'(wa.size()));
    chk("we addr0", 16'h0006, wa[0]);
    chk("we addr1", 16'h0007, wa[1]);
    chk("we data0", 16'h000A, wd[0]);
    chk("we data1", 16'h0064, wd[1]);
  endtask
  task automatic s_bad;
    pdu = {8'h07, 8'h00, 8'h00, 8'h00, 8'h01};
    xact(8'h01, 1'b0, 16'h0000);
    body = {8'h87, 8'h01};
    rsp_ok(16'h0003);
    pdu = {8'h04, 8'h00, 8'h07, 8'h00, 8'h02};
    xact(8'h01, 1'b0, 16'h0000);
    body = {8'h84, 8'h02};
    rsp_ok(16'h0003);
  endtask
  task automatic s_drop;
    pdu = {8'h05, 8'h00, 8'h00, 8'hFF, 8'h00};
    xact(8'h02, 1'b0, 16'h0000);
    chk("foreign unit", 16'h0000, 16'(rsp.size()));
    xact(8'h01, 1'b1, 16'h0000);
    chk("damaged", 16'h0000, 16'(rsp.size()));
    xact(8'h01, 1'b0, 16'h0001);
    chk("bad length", 16'h0000, 16'(rsp.size()));
    chk("dig kept", 16'h0102, dig);
  endtask
  // ------
  // main sequence and watchdog
  // ------
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk("reset dig", 16'h0000, dig);
    chk("reset tx", 16'h0000, {15'h0000, tx_valid});
    s_read;
    s_coil;
    s_reg;
    s_coils;
    s_regs;
    s_bad;
    s_drop;
    give_verdict;
  end
  // the whole sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    give_verdict;
  end
endmodule
`default_nettype wire
